// *** design/dbgtp_top.sv ***
// Notes on behaviour
// (RULE_01) Strap at reset selects scan or debug port
// (RULE_02) Test reset clears scan logic asynchronously
// (RULE_03) Mode select steps scan controller, rising edge
// (RULE_04) Test data taken on rising test clock
// (RULE_05) Test output driven only in shift states
// (RULE_06) Shift clock accepted after two equal samples
// (RULE_07) Host keeps shift clock at most status/5
// (RULE_08) Validated shift rise samples input, moves output
// (RULE_09) Serial output registered, lags clock validation
// (RULE_10) Breakpoint halts after instruction, shows 0xF
// (RULE_11) Breakpoint disabled raises debug interrupt instead
// (RULE_12) Status clock rises mid data window
// (RULE_13) Quiet freezes trace outputs, triggers still work; the first start code loads status and debug data even while quiet
// (RULE_14) Status clock waits for first start code (0xC, 0xD or 0xF)
// (RULE_15) Status follows core state every processor clock
// (RULE_16) All-status output is AND of status
// (RULE_17) Debug data shows capture and breakpoint state
// (RULE_18) Shift clock and input pass two flops
`timescale 1ns/100ps
`include "dbgtp_defs.svh"
module dbgtp_top (
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    // Port select strap
    input  wire logic        i_jtag_en,
    // Scan port
    input  wire logic        i_test_clock,
    input  wire logic        i_trst_n,
    input  wire logic        i_tms,
    input  wire logic        i_tdi,
    output logic             o_tdo,
    output logic             o_tdo_oe_n,
    // Debug serial port
    input  wire logic        i_debug_shift_clock,
    input  wire logic        i_debug_serial_in,
    output logic             o_debug_serial_out,
    // Breakpoint
    input  wire logic        i_breakpoint_request,
    input  wire logic        i_breakpoint_disable,
    // Real-time trace
    input  wire logic        i_trace_quiet,
    output logic             o_status_clock,
    output logic [3:0]       o_processor_status,
    output logic             o_all_status_and,
    output logic [3:0]       o_debug_data_out,
    // Core side
    input  wire logic [3:0]  i_core_status,
    input  wire logic        i_instr_done,
    input  wire logic        i_resume,
    input  wire logic        i_capture_valid,
    input  wire logic [3:0]  i_capture_data,
    input  wire logic [16:0] i_tx_data,
    output logic             o_rx_valid,
    output logic [16:0]      o_rx_data,
    output logic             o_halt,
    output logic             o_debug_irq,
    output logic             o_jtag_mode
);
    import dbgtp_pkg::*;

    dbgtp_main_t q;
    dbgtp_main_t d;
    logic        shift_rise;
    logic        breakpoint_request_rise;
    logic [3:0]  st_now;
    logic [3:0]  dd_now;

    dbgtp_if u_link ();

    // Scan controller runs on the test clock
    dbgtp_scan u_scan (
        .i_test_clock (i_test_clock),
        .i_trst_n     (i_trst_n),
        .i_tms        (i_tms),
        .i_tdi        (i_tdi),
        .link         (u_link.scan)
    );

    // Level crossing; the scan side synchronises it again
    assign u_link.enable = q.jtag_mode;                           // RULE_01

    // Edge of the validated shift clock and of the breakpoint pin
    assign shift_rise = (q.debug_shift_clock_s2 == q.debug_shift_clock_s3) &&
                        q.debug_shift_clock_s3 && !q.debug_shift_clock_lvl;               // RULE_06
    assign breakpoint_request_rise  = q.breakpoint_request_s2 && !q.breakpoint_request_s3;

    // Status and debug data that the trace would show now
    assign st_now = q.halt ? `DBGTP_ST_HALT : i_core_status;      // RULE_15
    assign dd_now = i_capture_valid ? i_capture_data :
                    {2'h0, q.cstate == DBGTP_HALT_WAIT, q.halt};  // RULE_17

    // Next state of the whole core-clock side
    always_comb begin
        d = q;
        d.rx_valid = 1'b0;
        d.irq      = 1'b0;

        // Strap is caught once the synchronisers hold real pin levels
        if (q.strap_cnt != `DBGTP_STRAP_CYC + 2'h1) begin
            d.strap_cnt = q.strap_cnt + 2'h1;
        end
        if (q.strap_cnt == `DBGTP_STRAP_CYC) begin
            d.jtag_mode = q.jtag_s2;                              // RULE_01
        end

        // Pin synchronisers; first stages feed only second stages
        d.jtag_s1  = i_jtag_en;
        d.jtag_s2  = q.jtag_s1;
        d.debug_shift_clock_s1 = i_debug_shift_clock;                         // RULE_18
        d.debug_shift_clock_s2 = q.debug_shift_clock_s1;                                  // RULE_18
        d.debug_shift_clock_s3 = q.debug_shift_clock_s2;
        d.dsi_s1   = i_debug_serial_in;                           // RULE_18
        d.dsi_s2   = q.dsi_s1;                                    // RULE_18
        d.breakpoint_request_s1  = i_breakpoint_request;
        d.breakpoint_request_s2  = q.breakpoint_request_s1;
        d.breakpoint_request_s3  = q.breakpoint_request_s2;

        // Accept a level only when two bus edges agree
        if (q.debug_shift_clock_s2 == q.debug_shift_clock_s3) begin
            d.debug_shift_clock_lvl = q.debug_shift_clock_s3;                             // RULE_06
        end

        // Serial shift; relies on the host clock staying slow enough
        // that no level is shorter than the two-sample window
        if (shift_rise && !q.jtag_mode) begin                     // RULE_01
            d.rx_sr   = {q.rx_sr[15:0], q.dsi_s2};                // RULE_08
            d.debug_serial_out     = q.tx_sr[16];                              // RULE_09
            d.tx_sr   = {q.tx_sr[15:0], 1'b0};
            d.bit_cnt = q.bit_cnt + 5'h01;
            if (q.bit_cnt == `DBGTP_PKT_LAST) begin
                d.bit_cnt  = 5'h00;
                d.rx_valid = 1'b1;
                d.rx_data  = {q.rx_sr[15:0], q.dsi_s2};
                d.tx_sr    = i_tx_data;
            end
        end

        // Run/halt sequencing; triggers work even while trace is quiet
        case (q.cstate)
            DBGTP_RUN: begin
                if (breakpoint_request_rise && i_breakpoint_disable) begin
                    d.irq = 1'b1;                                 // RULE_11
                end else if (breakpoint_request_rise) begin
                    d.cstate = DBGTP_HALT_WAIT;                   // RULE_10
                end
            end
            DBGTP_HALT_WAIT: begin
                if (i_instr_done) begin                           // RULE_10
                    d.cstate = DBGTP_HALTED;
                    d.halt   = 1'b1;
                end
            end
            DBGTP_HALTED: begin
                if (i_resume) begin
                    d.cstate = DBGTP_RUN;
                    d.halt   = 1'b0;
                end
            end
            default: d.cstate = DBGTP_RUN;
        endcase

        // Trace: one processor clock is two bus cycles
        if (!q.started) begin
            d.stat_clk = 1'b0;                                    // RULE_14
            if ((st_now == `DBGTP_ST_EXC_C) ||
                (st_now == `DBGTP_ST_EXC_D) ||
                (st_now == `DBGTP_ST_HALT)) begin
                d.started = 1'b1;
                d.status  = st_now;
                d.allst   = &st_now;
                d.debug_data_out   = dd_now;
                d.phase   = 1'b1;
            end
        end else if (i_trace_quiet) begin
            d.phase = 1'b0;                                       // RULE_13
        end else if (!q.phase) begin
            // New data with the clock low; edge comes mid window
            d.phase    = 1'b1;
            d.stat_clk = 1'b0;                                    // RULE_12
            d.status   = st_now;                                  // RULE_15
            d.allst    = &st_now;                                 // RULE_16
            d.debug_data_out    = dd_now;                                  // RULE_17
        end else begin
            d.phase    = 1'b0;
            d.stat_clk = 1'b1;                                    // RULE_12
        end

        // Synchronous reset overrides everything above
        if (!i_rst_n) begin
            d = '0;
            d.cstate = DBGTP_RUN;
        end
    end

    // Single register stage for the whole side
    always_ff @(posedge i_clk) begin
        q <= d;
    end

    // Outputs straight from flops
    assign o_tdo              = u_link.tdo;                       // RULE_05
    assign o_tdo_oe_n         = u_link.tdo_oe_n;                  // RULE_05
    assign o_debug_serial_out = q.debug_serial_out;                            // RULE_09
    assign o_status_clock     = q.stat_clk;
    assign o_processor_status = q.status;
    assign o_all_status_and   = q.allst;
    assign o_debug_data_out   = q.debug_data_out;
    assign o_rx_valid         = q.rx_valid;
    assign o_rx_data          = q.rx_data;
    assign o_halt             = q.halt;
    assign o_debug_irq        = q.irq;
    assign o_jtag_mode        = q.jtag_mode;
endmodule

// *** design/dbgtp_defs.svh ***
`ifndef DBGTP_DEFS_SVH
`define DBGTP_DEFS_SVH

// Serial debug packet length in bits
`define DBGTP_PKT_BITS      17
`define DBGTP_PKT_LAST      5'h10

// Processor status codes
`define DBGTP_ST_HALT       4'hF
`define DBGTP_ST_EXC_C      4'hC
`define DBGTP_ST_EXC_D      4'hD

// Scan instruction register
`define DBGTP_IR_BITS       4
`define DBGTP_IR_CAPTURE    4'h1
`define DBGTP_IR_IDCODE     4'h2
`define DBGTP_IR_BYPASS     4'hF

// Strap capture happens this many cycles after reset release
`define DBGTP_STRAP_CYC     2'h2

`endif

// *** design/dbgtp_pkg.sv ***
package dbgtp_pkg;

    // Scan controller states, one-hot
    typedef enum logic [15:0] {
        DBGTP_TLR  = 16'h0001, DBGTP_RTI  = 16'h0002,
        DBGTP_SDR  = 16'h0004, DBGTP_CDR  = 16'h0008,
        DBGTP_SHDR = 16'h0010, DBGTP_E1DR = 16'h0020,
        DBGTP_PDR  = 16'h0040, DBGTP_E2DR = 16'h0080,
        DBGTP_UDR  = 16'h0100, DBGTP_SIR  = 16'h0200,
        DBGTP_CIR  = 16'h0400, DBGTP_SHIR = 16'h0800,
        DBGTP_E1IR = 16'h1000, DBGTP_PIR  = 16'h2000,
        DBGTP_E2IR = 16'h4000, DBGTP_UIR  = 16'h8000
    } dbgtp_tap_t;

    // Processor run/halt states, one-hot
    typedef enum logic [2:0] {
        DBGTP_RUN       = 3'h1,
        DBGTP_HALT_WAIT = 3'h2,
        DBGTP_HALTED    = 3'h4
    } dbgtp_core_t;

    // State of the scan controller, apart from its two falling-edge output flops
    typedef struct packed {
        dbgtp_tap_t  tap;
        logic [3:0]  ir;
        logic [3:0]  ir_sr;
        logic [31:0] dr_sr;
        logic        en_s1;
        logic        en_s2;
    } dbgtp_scan_t;

    // All state of the core-clock side
    typedef struct packed {
        logic [1:0]  strap_cnt;
        logic        jtag_mode;
        logic        jtag_s1;
        logic        jtag_s2;
        logic        debug_shift_clock_s1;
        logic        debug_shift_clock_s2;
        logic        debug_shift_clock_s3;
        logic        debug_shift_clock_lvl;
        logic        dsi_s1;
        logic        dsi_s2;
        logic        breakpoint_request_s1;
        logic        breakpoint_request_s2;
        logic        breakpoint_request_s3;
        logic [16:0] rx_sr;
        logic [16:0] tx_sr;
        logic [4:0]  bit_cnt;
        logic        rx_valid;
        logic [16:0] rx_data;
        logic        debug_serial_out;
        dbgtp_core_t cstate;
        logic        halt;
        logic        irq;
        logic        started;
        logic        phase;
        logic        stat_clk;
        logic [3:0]  status;
        logic        allst;
        logic [3:0]  debug_data_out;
    } dbgtp_main_t;

endpackage

// *** design/dbgtp_if.sv ***
`timescale 1ns/100ps
// Link between the core side and the scan controller
interface dbgtp_if;
    logic enable;
    logic tdo;
    logic tdo_oe_n;

    modport scan (input enable, output tdo, output tdo_oe_n);
    modport core (output enable, input tdo, input tdo_oe_n);
endinterface

// *** design/dbgtp_scan.sv ***
`timescale 1ns/100ps
`include "dbgtp_defs.svh"
module dbgtp_scan #(
    parameter logic [31:0] P_IDCODE = 32'h0000_0001 // Arbitrary value
) (
    // Scan pins
    input  wire logic   i_test_clock,
    input  wire logic   i_trst_n,
    input  wire logic   i_tms,
    input  wire logic   i_tdi,
    // Core side
    dbgtp_if.scan       link
);
    import dbgtp_pkg::*;

    localparam dbgtp_scan_t SCAN_RST = '{tap: DBGTP_TLR,
        ir: `DBGTP_IR_IDCODE, default: '0};

    dbgtp_scan_t q;
    dbgtp_scan_t d;
    logic        tdo_q;
    logic        oe_n_q;

    // Next state; pins are taken on the rising test clock edge
    always_comb begin
        d = q;
        d.en_s1 = link.enable;
        d.en_s2 = q.en_s1;
        case (q.tap)                                              // RULE_03
            DBGTP_TLR:  d.tap = i_tms ? DBGTP_TLR  : DBGTP_RTI;
            DBGTP_RTI:  d.tap = i_tms ? DBGTP_SDR  : DBGTP_RTI;
            DBGTP_SDR:  d.tap = i_tms ? DBGTP_SIR  : DBGTP_CDR;
            DBGTP_CDR:  d.tap = i_tms ? DBGTP_E1DR : DBGTP_SHDR;
            DBGTP_SHDR: d.tap = i_tms ? DBGTP_E1DR : DBGTP_SHDR;
            DBGTP_E1DR: d.tap = i_tms ? DBGTP_UDR  : DBGTP_PDR;
            DBGTP_PDR:  d.tap = i_tms ? DBGTP_E2DR : DBGTP_PDR;
            DBGTP_E2DR: d.tap = i_tms ? DBGTP_UDR  : DBGTP_SHDR;
            DBGTP_UDR:  d.tap = i_tms ? DBGTP_SDR  : DBGTP_RTI;
            DBGTP_SIR:  d.tap = i_tms ? DBGTP_TLR  : DBGTP_CIR;
            DBGTP_CIR:  d.tap = i_tms ? DBGTP_E1IR : DBGTP_SHIR;
            DBGTP_SHIR: d.tap = i_tms ? DBGTP_E1IR : DBGTP_SHIR;
            DBGTP_E1IR: d.tap = i_tms ? DBGTP_UIR  : DBGTP_PIR;
            DBGTP_PIR:  d.tap = i_tms ? DBGTP_E2IR : DBGTP_PIR;
            DBGTP_E2IR: d.tap = i_tms ? DBGTP_UIR  : DBGTP_SHIR;
            DBGTP_UIR:  d.tap = i_tms ? DBGTP_SDR  : DBGTP_RTI;
            default:    d.tap = DBGTP_TLR;
        endcase
        // Capture, shift and update of the scan registers
        case (q.tap)
            DBGTP_TLR:  d.ir = `DBGTP_IR_IDCODE;
            DBGTP_CIR:  d.ir_sr = `DBGTP_IR_CAPTURE;
            DBGTP_SHIR: d.ir_sr = {i_tdi, q.ir_sr[3:1]};          // RULE_04
            DBGTP_UIR:  d.ir = q.ir_sr;
            DBGTP_CDR:  d.dr_sr = (q.ir == `DBGTP_IR_IDCODE) ?
                                  P_IDCODE : 32'h0000_0000;
            DBGTP_SHDR: begin
                if (q.ir == `DBGTP_IR_IDCODE) begin
                    d.dr_sr = {i_tdi, q.dr_sr[31:1]};             // RULE_04
                end else begin
                    d.dr_sr[0] = i_tdi;                           // RULE_04
                end
            end
            default: ;
        endcase
        // Unselected port: the controller is held in reset
        if (!q.en_s2) begin                                       // RULE_01
            d.tap = DBGTP_TLR;
            d.ir  = `DBGTP_IR_IDCODE;
        end
    end

    // Test reset acts at once, with no clock needed
    always_ff @(posedge i_test_clock or negedge i_trst_n) begin
        if (!i_trst_n) begin                                      // RULE_02
            q <= SCAN_RST;
        end else begin
            q <= d;
        end
    end

    // Output moves on the falling edge, half a period before sampling
    always_ff @(negedge i_test_clock or negedge i_trst_n) begin
        if (!i_trst_n) begin
            tdo_q  <= 1'b0;
            oe_n_q <= 1'b1;
        end else begin
            tdo_q  <= (q.tap == DBGTP_SHIR) ? q.ir_sr[0] : q.dr_sr[0];
            oe_n_q <= !((q.tap == DBGTP_SHIR) ||
                        (q.tap == DBGTP_SHDR));                   // RULE_05
        end
    end

    assign link.tdo      = tdo_q;
    assign link.tdo_oe_n = oe_n_q;
endmodule

// *** test/dbgtp_top_sva.sv ***
`timescale 1ns/100ps
module dbgtp_top_sva (
    // Clocks and resets
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_trst_n,
    input  wire logic       i_test_clock,
    // Levels from host and core
    input  wire logic       i_debug_shift_clock,
    input  wire logic       i_breakpoint_disable,
    input  wire logic       i_trace_quiet,
    // Watched outputs
    input  wire logic       o_tdo,
    input  wire logic       o_tdo_oe_n,
    input  wire logic       o_debug_serial_out,
    input  wire logic       o_rx_valid,
    input  wire logic       o_debug_irq,
    input  wire logic       o_halt,
    input  wire logic       o_status_clock,
    input  wire logic [3:0] o_processor_status,
    input  wire logic       o_all_status_and,
    input  wire logic [3:0] o_debug_data_out
);
    logic started_q;
    logic started_d;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    // Trace counts as begun once a start code has been shown
    always_comb begin
        started_d = started_q ||
                    (o_processor_status inside {4'hC, 4'hD, 4'hF});
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            started_q <= 1'b0;
        end else begin
            started_q <= started_d;
        end
    end

    AST_ALL_AND: assert property (
        o_all_status_and == &o_processor_status) else $error("and mismatch");
    AST_TRST_OFF: assert property (
        !i_trst_n |-> o_tdo_oe_n) else $error("tdo driven in test reset");
    AST_TDO_FALL: assert property (
        i_trst_n && $past(i_trst_n) &&
        ($changed(o_tdo) || $changed(o_tdo_oe_n))
        |-> !i_test_clock) else $error("tdo moved off falling edge");
    AST_RX_SYNC: assert property (
        o_rx_valid |-> $past(i_debug_shift_clock, 2) ##1 !o_rx_valid)
        else $error("packet taken without two equal samples");
    AST_DSO_LAG: assert property (
        $changed(o_debug_serial_out)
        |-> $past(i_debug_shift_clock, 2) && i_debug_shift_clock)
        else $error("serial out moved without validated rise");
    AST_IRQ_CAUSE: assert property (
        o_debug_irq |-> i_breakpoint_disable && !o_halt ##1 !o_debug_irq)
        else $error("bad debug interrupt");
    AST_HALT_CODE: assert property (
        $rose(o_halt) && !i_trace_quiet && !i_breakpoint_disable
        |-> ##[1:4] o_processor_status == 4'hF) else $error("no halt code");
    AST_QUIET_HOLD: assert property (
        i_trace_quiet && $past(i_trace_quiet) |-> $stable(o_status_clock)
        && $stable(o_processor_status) && $stable(o_debug_data_out))
        else $error("trace moved while quiet");
    AST_CLK_START: assert property (
        o_status_clock |-> started_q) else $error("trace clock early");
    AST_DATA_WIN: assert property (
        $changed(o_processor_status) || $changed(o_debug_data_out)
        |-> !o_status_clock) else $error("trace data moved on clock high");

    // Main scenarios reached
    COV_RX: cover property (o_rx_valid);
    COV_HALT: cover property ($rose(o_halt));
    COV_IRQ: cover property (o_debug_irq);
endmodule

bind dbgtp_top dbgtp_top_sva chk_u (
    .i_clk, .i_rst_n, .i_trst_n, .i_test_clock, .i_debug_shift_clock,
    .i_breakpoint_disable, .i_trace_quiet, .o_tdo, .o_tdo_oe_n,
    .o_debug_serial_out, .o_rx_valid, .o_debug_irq, .o_halt,
    .o_status_clock, .o_processor_status, .o_all_status_and,
    .o_debug_data_out
);

// *** test/dbgtp_host.sv ***
`timescale 1ns/100ps
module dbgtp_host (
    // Pacing clock
    input  wire logic i_clk,
    // Serial debug pins
    output logic      o_sclk,
    output logic      o_sdi,
    input  wire logic i_sdo
);
    // Ten cycles a phase: a 120 ns bit, three times the shortest legal one
    localparam int P_HALF = 10;

    initial begin
        o_sclk = 1'b0;
        o_sdi = 1'b0;
    end

    // One packet, msb first both ways; clock idles low between packets
    task automatic xfer(input logic [16:0] tx, output logic [16:0] rx);
        for (int k = 16; k >= 0; k--) begin
            o_sdi = tx[k];
            repeat (P_HALF) @(negedge i_clk);
            o_sclk = 1'b1;
            repeat (P_HALF) @(negedge i_clk);
            rx[k] = i_sdo;
            o_sclk = 1'b0;
            repeat (P_HALF) @(negedge i_clk);
        end
        // Released data line must not look like a held bit
        o_sdi = ~tx[0];
    endtask
endmodule

// *** test/dbgtp_top_tb.sv ***
`timescale 1ns/100ps
module dbgtp_top_tb;
    // Scan identity as built into the design; value is arbitrary
    localparam logic [31:0] P_ID = 32'h0000_0001;
    logic        i_clk, i_rst_n, i_jtag_en, i_test_clock, i_trst_n, i_tms;
    logic        i_tdi, i_breakpoint_request, i_breakpoint_disable;
    logic        i_trace_quiet, i_instr_done, i_resume, i_capture_valid;
    logic [3:0]  i_core_status, i_capture_data, o_processor_status;
    logic [3:0]  o_debug_data_out;
    logic [16:0] i_tx_data, o_rx_data;
    wire         i_debug_shift_clock, i_debug_serial_in;
    logic        o_tdo, o_tdo_oe_n, o_debug_serial_out, o_status_clock;
    logic        o_all_status_and, o_rx_valid, o_halt, o_debug_irq;
    logic        o_jtag_mode, sc_q;
    int          fails, num_checks, rxc, irqc, stc;

    dbgtp_top dut_u (
        .i_clk, .i_rst_n, .i_jtag_en, .i_test_clock, .i_trst_n, .i_tms,
        .i_tdi, .o_tdo, .o_tdo_oe_n, .i_debug_shift_clock,
        .i_debug_serial_in, .o_debug_serial_out, .i_breakpoint_request,
        .i_breakpoint_disable, .i_trace_quiet, .o_status_clock,
        .o_processor_status, .o_all_status_and, .o_debug_data_out,
        .i_core_status, .i_instr_done, .i_resume, .i_capture_valid,
        .i_capture_data, .i_tx_data, .o_rx_valid, .o_rx_data, .o_halt,
        .o_debug_irq, .o_jtag_mode
    );
    dbgtp_host host_u (
        .i_clk, .o_sclk(i_debug_shift_clock), .o_sdi(i_debug_serial_in),
        .i_sdo(o_debug_serial_out)
    );

    always #2 i_clk = ~i_clk;

    // Event counters read pre-edge values, so no race with the design
    always @(posedge i_clk) begin
        rxc += o_rx_valid;
        irqc += o_debug_irq;
        stc += (o_status_clock && !sc_q);
        sc_q = o_status_clock;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic final_report();
        $display("checks=%0d fails=%0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge i_clk);
    endtask

    task automatic do_reset(input logic jtag);
        i_jtag_en = jtag;
        i_rst_n = 1'b0;
        i_trst_n = 1'b1;
        cyc(1);
        // A real falling edge, so the scan side resets for certain
        i_trst_n = 1'b0;
        cyc(11);
        i_rst_n = 1'b1;
        i_trst_n = 1'b1;
        cyc(6);
    endtask

    // One test clock period; the clock stands low between calls
    task automatic tck(input logic ms, input logic di);
        i_tms = ms;
        i_tdi = di;
        #80 i_test_clock = 1'b1;
        #80 i_test_clock = 1'b0;
    endtask

    task automatic walk(input int n, input logic [15:0] ms);
        for (int i = 0; i < n; i++) tck(ms[i], 1'b0);
    endtask

    task automatic shift(input int n, input logic [31:0] din,
                         output logic [31:0] dout);
        dout = '0;
        for (int i = 0; i < n; i++) begin
            #1 dout[i] = o_tdo;
            chk(o_tdo_oe_n, 1'b0);
            tck(i == n - 1, din[i]);
        end
        #1 chk(o_tdo_oe_n, 1'b1);
    endtask

    task automatic t_trace();
        stc = 0;
        cyc(10);
        chk(stc, 0);
        i_core_status = 4'hC;
        cyc(10);
        chk(o_processor_status, 4'hC);
        chk(stc > 2, 1'b1);
        i_trace_quiet = 1'b1;
        cyc(2);
        i_core_status = 4'h5;
        stc = 0;
        cyc(10);
        chk(stc, 0);
        chk(o_processor_status, 4'hC);
        i_trace_quiet = 1'b0;
        i_capture_valid = 1'b1;
        i_capture_data = 4'hA;
        cyc(6);
        chk(o_processor_status, 4'h5);
        chk(o_debug_data_out, 4'hA);
        chk(stc > 1, 1'b1);
        i_capture_valid = 1'b0;
        $display("trace test done");
    endtask

    task automatic t_break(input logic dis);
        irqc = 0;
        i_breakpoint_disable = dis;
        i_breakpoint_request = 1'b1;
        cyc(10);
        i_breakpoint_request = 1'b0;
        chk(irqc, dis);
        chk(o_halt, 1'b0);
        chk(o_debug_data_out, {2'b00, ~dis, 1'b0});
        i_instr_done = 1'b1;
        cyc(8);
        i_instr_done = 1'b0;
        chk(o_halt, !dis);
        chk(o_processor_status, dis ? 4'h5 : 4'hF);
        chk(o_all_status_and, !dis);
        i_resume = 1'b1;
        cyc(4);
        i_resume = 1'b0;
        cyc(4);
        chk(o_halt, 1'b0);
        $display("breakpoint test done");
    endtask

    task automatic t_serial();
        logic [16:0] r;
        rxc = 0;
        i_tx_data = 17'h0C3C3;
        host_u.xfer(17'h1A5A5, r);
        chk(r, 17'h0);
        chk(o_rx_data, 17'h1A5A5);
        host_u.xfer(17'h00F0F, r);
        chk(r, 17'h0C3C3);
        chk(o_rx_data, 17'h00F0F);
        chk(rxc, 2);
        walk(9, 16'h005F);
        #1 chk(o_tdo_oe_n, 1'b1);
        $display("serial test done");
    endtask

    task automatic t_scan();
        logic [31:0] got;
        do_reset(1'b1);
        chk(o_jtag_mode, 1'b1);
        walk(9, 16'h005F);
        shift(32, 32'h0, got);
        chk(got, P_ID);
        walk(5, 16'h0007);
        shift(4, 32'hF, got);
        chk(got, 32'h1);
        walk(4, 16'h0003);
        shift(8, 32'hB4, got);
        chk(got, 32'h68);
        walk(3, 16'h0002);
        #1 chk(o_tdo_oe_n, 1'b0);
        i_trst_n = 1'b0;
        #1 chk(o_tdo_oe_n, 1'b1);
        cyc(3);
        $display("scan test done");
    endtask

    initial begin
        {i_clk, i_test_clock, i_tms} = '0;
        {i_tdi, i_breakpoint_request, i_breakpoint_disable} = '0;
        {i_trace_quiet, i_instr_done, i_resume, i_capture_valid} = '0;
        {i_core_status, i_capture_data, i_tx_data, sc_q} = '0;
        {fails, num_checks, rxc, irqc, stc} = '0;
        do_reset(1'b0);
        chk(o_jtag_mode, 1'b0);
        t_trace();
        t_break(1'b1);
        t_break(1'b0);
        t_serial();
        t_scan();
        final_report();
    end

    // Tests need about 16.5 us; six times that means a hang
    initial begin
        #100000;
        fails++;
        final_report();
    end
endmodule
